// File: verilog/stc_pkg.sv
// package: register map, control layout and constants of the timer
package stc_pkg;

	// ==========================================================
	// bus geometry
	localparam int unsigned STC_ADDR_W = 8;
	localparam int unsigned STC_DATA_W = 32;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_COUNT_LOW = 8'h00;
	localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
	localparam logic [7:0] OFF_TIMER_CONTROL = 8'h08;
	localparam logic [7:0] OFF_IRQ_FLAG = 8'h0c;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFF_COMPANION_CONTROL = 8'h14;

	// ==========================================================
	// field positions
	localparam int unsigned BIT_OVERFLOW = 1;
	localparam int unsigned BIT_AUX_OSC_EN = 3;

	// ==========================================================
	// reset values and constants
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb;
	localparam int unsigned INSTR_DIV = 4;
	localparam int unsigned PRESCALE_W = 3;

	// ==========================================================
	// timer control register layout, bit 7 first
	typedef struct packed {
		logic wide_access_enable;
		logic time_base_select_hi;
		logic [1:0] input_prescale_field;
		logic time_base_select_lo;
		logic external_sync_bit;
		logic clock_source_select;
		logic counting_on_bit;
	} stc_ctrl_type;

	localparam stc_ctrl_type RST_CTRL = stc_ctrl_type'(RST_BYTE);

	// ==========================================================
	// pin group of the shared oscillator pins
	typedef struct packed {
		logic [1:0] oe;
		logic [1:0] rd;
	} stc_pins_type;

endpackage

// File: verilog/stc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module stc_sync
	import stc_pkg::*;
#(
	parameter int unsigned WIDTH = 4
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// ==========================================================
	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule // stc_sync

// File: verilog/stc_prescaler.sv
// input prescaler: divides count ticks by 1, 2, 4 or 8
`timescale 1ns/100ps
module stc_prescaler
	import stc_pkg::*;
#(
	parameter int unsigned CNT_W = PRESCALE_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic in_tick,
	input wire logic [1:0] ratio,
	output logic out_tick
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] mask;

	assign mask = CNT_W'((1 << ratio) - 1);
	assign out_tick = in_tick && ((cnt_ff & mask) == mask) && !clear;

	// ==========================================================
	// prescale counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_ff <= '0;
		else if (clear)
			cnt_ff <= '0;
		else if (in_tick)
			cnt_ff <= cnt_ff + CNT_W'(1);
	end

endmodule // stc_prescaler

// File: verilog/stc_timer.sv
// 16-bit timer/counter with apb register access
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps

module stc_timer
	import stc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [STC_ADDR_W-1:0] paddr,
	input wire logic [STC_DATA_W-1:0] pwdata,
	output logic [STC_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clk_pin,
	input wire logic aux_osc_clk,
	input wire logic [1:0] port_pin_in,
	input wire logic [1:0] port_dir_out,
	output logic [1:0] port_pin_oe,
	output logic [1:0] port_read,
	input wire logic [3:0] compare_mode,
	input wire logic compare_match,
	input wire logic adc_enable,
	output logic adc_start,
	output logic [1:0] time_base_select,
	output logic irq
);

	// ==========================================================
	// declarations
	stc_ctrl_type ctrl_ff;
	logic [7:0] companion_ff;
	logic [15:0] count_ff;
	logic [15:0] nxt_count;
	logic [7:0] high_buf_ff;
	logic [7:0] irq_flag_ff;
	logic [7:0] irq_enable_ff;
	logic [STC_DATA_W-1:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic irq_ff;
	logic adc_start_ff;
	logic [1:0] time_base_ff;
	stc_pins_type pins_ff;
	logic [1:0] instr_div_ff;
	logic src_dly_ff;
	logic edge_sync_ff;
	logic [3:0] pin_sync;
	logic aux_en;
	logic src_level;
	logic src_rise;
	logic ext_tick;
	logic instr_tick;
	logic src_tick;
	logic inc_tick;
	logic special_ev;
	logic wrap;
	logic acc;
	logic wr_done;
	logic rd_take;
	logic wr_low;
	logic wr_high;
	logic rd_low;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;
	logic rd_err;

	// ==========================================================
	// apb phases
	assign acc = psel && penable;
	assign wr_done = acc && pready_ff && pwrite;
	assign rd_take = acc && !pready_ff && !pwrite;
	assign wbyte = pwdata[7:0];
	assign wr_low = wr_done && (paddr == OFF_COUNT_LOW);
	assign wr_high = wr_done && (paddr == OFF_COUNT_HIGH);
	assign rd_low = rd_take && (paddr == OFF_COUNT_LOW);

	// ==========================================================
	// pin synchroniser
	stc_sync #(
		.WIDTH(4)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({port_pin_in, aux_osc_clk, ext_clk_pin}),
		.sync_out(pin_sync)
	);

	// ==========================================================
	// count source selection
	assign aux_en = companion_ff[BIT_AUX_OSC_EN];
	// oscillator output replaces the external pin when enabled
	assign src_level = aux_en ? pin_sync[1] : pin_sync[0];
	assign src_rise = src_level && !src_dly_ff;
	// sync bit set: raw edge, clear: one extra resync stage
	assign ext_tick = ctrl_ff.external_sync_bit ? src_rise :
		edge_sync_ff;
	assign instr_tick = (instr_div_ff == 2'(INSTR_DIV - 1));
	assign src_tick = ctrl_ff.clock_source_select ? ext_tick :
		instr_tick;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_dly_ff <= 1'b0;
			edge_sync_ff <= 1'b0;
		end
		else
		begin
			src_dly_ff <= src_level;
			edge_sync_ff <= src_rise;
		end
	end

	// instruction cycle divider, pclk / 4
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			instr_div_ff <= 2'b00;
		else
			instr_div_ff <= instr_div_ff + 2'b01;
	end

	// ==========================================================
	// prescaler
	stc_prescaler #(
		.CNT_W(PRESCALE_W)
	) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.clear(wr_low),
		.in_tick(src_tick && ctrl_ff.counting_on_bit),
		.ratio(ctrl_ff.input_prescale_field),
		.out_tick(inc_tick)
	);

	// ==========================================================
	// count register
	assign special_ev = compare_match &&
		(compare_mode == MODE_SPECIAL_EVENT);
	assign wrap = inc_tick && (count_ff == COUNT_MAX);

	always_comb
	begin
		nxt_count = count_ff;
		if (wr_low)
		begin
			nxt_count[7:0] = wbyte;
			// wide mode: live high byte loads from the buffer
			if (ctrl_ff.wide_access_enable)
				nxt_count[15:8] = high_buf_ff;
		end
		else if (wr_high && !ctrl_ff.wide_access_enable)
			nxt_count[15:8] = wbyte;
		else if (special_ev && !wr_high)
			// a write in the same cycle takes precedence
			nxt_count = RST_COUNT;
		else if (inc_tick)
			nxt_count = count_ff + 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_ff <= RST_COUNT;
		else
			count_ff <= nxt_count;
	end

	// ==========================================================
	// high byte buffer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			high_buf_ff <= RST_BYTE;
		else if (wr_high && ctrl_ff.wide_access_enable)
			high_buf_ff <= wbyte;
		else if (rd_low && ctrl_ff.wide_access_enable)
			high_buf_ff <= count_ff[15:8];
	end

	// ==========================================================
	// control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_ff <= RST_CTRL;
		else if (wr_done && (paddr == OFF_TIMER_CONTROL))
			ctrl_ff <= stc_ctrl_type'(wbyte);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			companion_ff <= RST_BYTE;
		else if (wr_done && (paddr == OFF_COMPANION_CONTROL))
			companion_ff <= wbyte;
	end

	// ==========================================================
	// interrupt flag and enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_flag_ff <= RST_BYTE;
		else if (wrap)
			// set wins over a coinciding clear
			irq_flag_ff[BIT_OVERFLOW] <= 1'b1;
		else if (wr_done && (paddr == OFF_IRQ_FLAG))
			irq_flag_ff <= irq_flag_ff & ~wbyte;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_enable_ff <= RST_BYTE;
		else if (wr_done && (paddr == OFF_IRQ_ENABLE))
			irq_enable_ff <= wbyte;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_ff <= 1'b0;
		else
			irq_ff <= irq_flag_ff[BIT_OVERFLOW] &&
				irq_enable_ff[BIT_OVERFLOW];
	end

	// ==========================================================
	// compare side outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			adc_start_ff <= 1'b0;
			time_base_ff <= 2'b00;
		end
		else
		begin
			adc_start_ff <= special_ev && adc_enable;
			time_base_ff <= {ctrl_ff.time_base_select_hi,
				ctrl_ff.time_base_select_lo};
		end
	end

	// ==========================================================
	// oscillator pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pins_ff <= '0;
		else
		begin
			pins_ff.oe <= aux_en ? 2'b00 : port_dir_out;
			pins_ff.rd <= aux_en ? 2'b00 : pin_sync[3:2];
		end
	end

	// ==========================================================
	// read data selection
	always_comb
	begin
		rd_byte = RST_BYTE;
		rd_err = 1'b0;
		unique case (paddr)
			OFF_COUNT_LOW:
				rd_byte = count_ff[7:0];
			OFF_COUNT_HIGH:
				rd_byte = ctrl_ff.wide_access_enable ? high_buf_ff :
					count_ff[15:8];
			OFF_TIMER_CONTROL:
				rd_byte = ctrl_ff;
			OFF_IRQ_FLAG:
				rd_byte = irq_flag_ff;
			OFF_IRQ_ENABLE:
				rd_byte = irq_enable_ff;
			OFF_COMPANION_CONTROL:
				rd_byte = companion_ff;
			default:
				rd_err = 1'b1;
		endcase
	end

	// ==========================================================
	// apb answer: one wait state, then pready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end
		else if (acc && !pready_ff)
		begin
			pready_ff <= 1'b1;
			pslverr_ff <= rd_err;
			prdata_ff <= pwrite ? '0 : {24'h00_0000, rd_byte};
		end
		else
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end
	end

	// ==========================================================
	// outputs
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign port_pin_oe = pins_ff.oe;
	assign port_read = pins_ff.rd;
	assign adc_start = adc_start_ff;
	assign time_base_select = time_base_ff;
	assign irq = irq_ff;

endmodule // stc_timer

// File: tb/stc_timer_sva.sv
// checker: bus and pin relations at the timer ports
`timescale 1ns/100ps
module stc_timer_sva
	import stc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [STC_ADDR_W-1:0] paddr,
	input wire logic [STC_DATA_W-1:0] pwdata,
	input wire logic [STC_DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] port_dir_out,
	input wire logic [1:0] port_pin_oe,
	input wire logic [1:0] port_read,
	input wire logic [3:0] compare_mode,
	input wire logic compare_match,
	input wire logic adc_enable,
	input wire logic adc_start,
	input wire logic [1:0] time_base_select,
	input wire logic irq
);
	// ==========================================================
	// properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_ok;
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;
	property p_one_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("pready late");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready held");
	property p_rd_idle;
		!pready |-> prdata == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("prdata idle");
	property p_unmapped;
		pready && paddr > OFF_COMPANION_CONTROL |-> pslverr && prdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no slverr");
	property p_adc;
		compare_match && compare_mode == MODE_SPECIAL_EVENT && adc_enable
			|=> adc_start;
	endproperty
	a_adc: assert property (p_adc) else $error("adc start missing");
	property p_adc_cause;
		adc_start |-> $past(compare_match) && $past(adc_enable)
			&& $past(compare_mode) == MODE_SPECIAL_EVENT;
	endproperty
	a_adc_cause: assert property (p_adc_cause) else $error("adc cause");
	property p_tbase;
		wr_ok && paddr == OFF_TIMER_CONTROL |-> ##2
			time_base_select == {$past(pwdata[6], 2), $past(pwdata[3], 2)};
	endproperty
	a_tbase: assert property (p_tbase) else $error("time base");
	property p_osc_pins;
		wr_ok && paddr == OFF_COMPANION_CONTROL && pwdata[BIT_AUX_OSC_EN]
			|-> ##2 port_read == 2'h0 && port_pin_oe == 2'h0;
	endproperty
	a_osc_pins: assert property (p_osc_pins) else $error("osc pins");
	property p_oe;
		(port_pin_oe & ~$past(port_dir_out)) == 2'h0;
	endproperty
	a_oe: assert property (p_oe) else $error("pin driven");
	property p_mask;
		wr_ok && paddr == OFF_IRQ_ENABLE && !pwdata[BIT_OVERFLOW] |-> ##2 !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("irq unmasked");
	c_adc: cover property (adc_start);
	c_irq: cover property (irq);
	c_err: cover property (pready && pslverr);
endmodule // stc_timer_sva

bind stc_timer stc_timer_sva i_sva (.*);

// File: tb/stc_osc_model.sv
// partner: external count pin and auxiliary oscillator
`timescale 1ns/100ps
module stc_osc_model
#(
	parameter int HALF = 3
)
(
	input wire logic pclk,
	input wire logic run,
	input wire logic use_aux,
	output logic ext_clk_pin,
	output logic aux_osc_clk,
	output int edges
);
	// ==========================================================
	// one level routed to the chosen source, idle low
	int cnt = 0;
	logic lvl = 1'b0;
	initial edges = 0;
	assign ext_clk_pin = !use_aux && lvl;
	assign aux_osc_clk = use_aux && lvl;
	always @(posedge pclk)
	begin
		if (run || lvl)
		begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
			begin
				lvl <= !lvl;
				if (!lvl)
					edges <= edges + 1;
			end
		end
	end
endmodule // stc_osc_model

// File: tb/tb_sixteen_bit_timer_counter.sv
// testbench: registers, counting, overflow and special event
`timescale 1ns/100ps
module tb_sixteen_bit_timer_counter
	import stc_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [STC_ADDR_W-1:0] paddr = '0;
	logic [STC_DATA_W-1:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, adc_start, irq, run = 0, use_aux = 0;
	logic ext_clk_pin, aux_osc_clk, compare_match = 0, adc_enable = 1;
	logic [1:0] port_pin_in = '0, port_dir_out = '0, port_pin_oe, port_read;
	logic [1:0] time_base_select;
	logic [3:0] compare_mode = '0;
	logic [15:0] v;
	int edges, mismatches = 0, total_checks = 0, cycles = 0, e0, t0;
	int seed = 32'h8f09_3a0b;
	stc_timer i_dut (.*);
	stc_osc_model i_osc (.*);
	initial forever #12.5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		port_pin_in <= 2'($random(seed));
		port_dir_out <= 2'($random(seed));
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, string w);
		apb(1'b0, a, '0);
		chk(w, rd, e);
	endtask
	task automatic pulses(input int n);
		e0 = edges;
		@(posedge pclk);
		run <= 1'b1;
		while (edges - e0 < n) @(negedge pclk);
		@(posedge pclk);
		run <= 1'b0;
		repeat (12) @(posedge pclk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 24; a += 4)
		begin
			apb(1'b0, 8'(a), '0);
			chk("reset", rd, '0);
			chk("slverr", 32'(er), 32'(a == 24));
		end
		v = 16'($random(seed));
		apb(1'b1, OFF_COUNT_LOW, 32'(v[7:0]));
		apb(1'b1, OFF_COUNT_HIGH, 32'(v[15:8]));
		rchk(OFF_COUNT_HIGH, 32'(v[15:8]), "high");
		rchk(OFF_COUNT_LOW, 32'(v[7:0]), "low");
		apb(1'b1, OFF_TIMER_CONTROL, 32'h80);
		apb(1'b1, OFF_COUNT_HIGH, 32'h3c);
		apb(1'b1, OFF_COUNT_LOW, 32'hc3);
		apb(1'b1, OFF_COUNT_HIGH, 32'h99);
		rchk(OFF_COUNT_HIGH, 32'h99, "buffer");
		rchk(OFF_COUNT_LOW, 32'hc3, "wide low");
		rchk(OFF_COUNT_HIGH, 32'h3c, "wide high");
		for (int i = 0; i < 5; i++)
		begin
			use_aux <= i[0];
			apb(1'b1, OFF_COMPANION_CONTROL, 32'(i[0]) << BIT_AUX_OSC_EN);
			v = 16'(2 | (i < 4) | (i % 4) << 4 | i[1] << 2
				| ($random(seed) & 32'h48));
			apb(1'b1, OFF_TIMER_CONTROL, 32'(v));
			apb(1'b1, OFF_COUNT_LOW, '0);
			pulses(1);
			apb(1'b1, OFF_COUNT_HIGH, '0);
			pulses(15);
			rchk(OFF_COUNT_LOW, 32'((i < 4) ? 16 >> i : 0), "edges");
			if (i[0])
				chk("pins", 32'({port_read, port_pin_oe}), '0);
			chk("tbase", 32'(time_base_select), 32'({v[6], v[3]}));
		end
		apb(1'b1, OFF_IRQ_ENABLE, 32'h2);
		apb(1'b1, OFF_TIMER_CONTROL, 32'h3);
		apb(1'b1, OFF_COUNT_HIGH, 32'hff);
		apb(1'b1, OFF_COUNT_LOW, 32'hff);
		pulses(3);
		rchk(OFF_COUNT_LOW, 32'h2, "wrap");
		rchk(OFF_IRQ_FLAG, 32'h2, "flag");
		chk("irq", 32'(irq), 32'h1);
		apb(1'b1, OFF_IRQ_ENABLE, '0);
		repeat (2) @(posedge pclk);
		chk("masked", 32'(irq), '0);
		apb(1'b1, OFF_IRQ_FLAG, 32'h2);
		apb(1'b1, OFF_IRQ_ENABLE, 32'h2);
		rchk(OFF_IRQ_FLAG, '0, "cleared");
		chk("irq off", 32'(irq), '0);
		apb(1'b1, OFF_TIMER_CONTROL, '0);
		compare_mode <= 4'($random(seed)) | 4'h4;
		compare_match <= 1'b1;
		apb(1'b1, OFF_COUNT_LOW, 32'h55);
		rchk(OFF_COUNT_LOW, 32'h55, "other mode");
		compare_mode <= MODE_SPECIAL_EVENT;
		apb(1'b1, OFF_COUNT_LOW, 32'h66);
		compare_match <= 1'b0;
		rchk(OFF_COUNT_LOW, 32'h66, "write wins");
		for (int k = 0; k < 2; k++)
		begin
			adc_enable <= k[0];
			compare_match <= 1'b1;
			@(posedge pclk);
			compare_match <= 1'b0;
			@(posedge pclk);
			chk("adc", 32'(adc_start), 32'(k));
		end
		rchk(OFF_COUNT_LOW, '0, "event reset");
		rchk(OFF_IRQ_FLAG, '0, "no flag");
		apb(1'b1, OFF_TIMER_CONTROL, 32'h1);
		apb(1'b1, OFF_COUNT_LOW, '0);
		t0 = cycles;
		repeat (200) @(posedge pclk);
		apb(1'b1, OFF_TIMER_CONTROL, '0);
		t0 = (cycles - t0) / INSTR_DIV;
		apb(1'b0, OFF_COUNT_LOW, '0);
		chk("timer", 32'(rd + 2 >= t0 && rd <= t0 + 2), 32'h1);
		give_verdict();
	end
endmodule // tb_sixteen_bit_timer_counter
